// File: rtl/sfdp_pkg.sv
// Package with constants and types for the serial controller FIFO data windows
`default_nettype none
package sfdp_pkg;

	// Window decode uses the low ten address bits
	localparam int unsigned ADDR_W       = 10;
	localparam int unsigned DATA_W       = 32;
	localparam int unsigned FIFO_DEPTH   = 32;
	localparam int unsigned CNT_W        = 6;

	// Transmit data window, write only
	localparam logic [9:0] TX_WIN_LO     = 10'h010;
	localparam logic [9:0] TX_WIN_HI     = 10'h02F;
	// Receive data window, read only
	localparam logic [9:0] RX_WIN_LO     = 10'h030;
	localparam logic [9:0] RX_WIN_HI     = 10'h04F;

	// Value read from the receive window after reset or when empty
	localparam logic [31:0] RX_RESET_VAL = 32'h0000_0000;
	localparam logic [31:0] READ_ZERO    = 32'h0000_0000;

	// Access size codes carried with every bus transfer
	typedef enum logic [1:0] {
		SFDP_SIZE_BYTE = 2'b00,
		SFDP_SIZE_HALF = 2'b01,
		SFDP_SIZE_WORD = 2'b10,
		SFDP_SIZE_RSVD = 2'b11
	} sfdp_size_t;

	// Bus request as seen at the slave pins
	typedef struct packed {
		logic                sel;
		logic                enable;
		logic                write;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   wdata;
		sfdp_size_t          size;
	} sfdp_apb_req_t;

	// Number of bytes moved by one access of the given size
	function automatic logic [2:0] sfdp_bytes(input sfdp_size_t size);
		logic [2:0] n;
		n = 3'h0;
		unique case (size)
			SFDP_SIZE_BYTE: n = 3'h1;
			SFDP_SIZE_HALF: n = 3'h2;
			SFDP_SIZE_WORD: n = 3'h4;
			SFDP_SIZE_RSVD: n = 3'h0;
		endcase
		return n;
	endfunction : sfdp_bytes

endpackage : sfdp_pkg
`default_nettype wire

// File: rtl/sfdp_byte_fifo.sv
// Byte FIFO that accepts and releases up to four bytes per clock
`timescale 1ns/1ps
`default_nettype none
module sfdp_byte_fifo #(
	parameter int unsigned DEPTH = sfdp_pkg::FIFO_DEPTH,
	parameter int unsigned CW    = sfdp_pkg::CNT_W
) (
	input  wire logic          clk,
	input  wire logic          resetn,
	input  wire logic [2:0]    push_n,
	input  wire logic [31:0]   push_data,
	input  wire logic [2:0]    pop_n,
	output logic      [31:0]   peek_data,
	output logic      [CW-1:0] count_q
);

	// Depth must be a power of two so pointers wrap by truncation
	localparam int unsigned PW = $clog2(DEPTH);

	logic [7:0]    mem [DEPTH];
	logic [PW-1:0] wr_ptr_q;
	logic [PW-1:0] rd_ptr_q;

	// Storage: byte i of the word goes to the in pointer plus i, least significant first
	always_ff @(posedge clk) begin
		for (int i = 0; i < 4; i++) begin
			if (3'(i) < push_n) begin
				mem[PW'(wr_ptr_q + PW'(i))] <= push_data[8*i +: 8];
			end
		end
	end

	// Pointers wrap at the depth; the count tells full from empty
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			wr_ptr_q <= PW'(wr_ptr_q + PW'(push_n));
			rd_ptr_q <= PW'(rd_ptr_q + PW'(pop_n));
			count_q  <= CW'(count_q + CW'(push_n) - CW'(pop_n));
		end
	end

	// Head bytes seen from the out pointer; unfilled lanes show stale storage
	always_comb begin
		peek_data = '0;
		for (int i = 0; i < 4; i++) begin
			peek_data[8*i +: 8] = mem[PW'(rd_ptr_q + PW'(i))];
		end
	end

endmodule : sfdp_byte_fifo
`default_nettype wire

// File: rtl/sfdp_data_port.sv
// Bus data windows onto the transmit and receive byte FIFOs of the serial controller
`timescale 1ns/1ps
`default_nettype none
module sfdp_data_port #(
	parameter int unsigned DEPTH = sfdp_pkg::FIFO_DEPTH
) (
	input  wire logic                  clk,
	input  wire logic                  resetn,
	input  wire sfdp_pkg::sfdp_apb_req_t apb,
	output logic      [31:0]           prdata_q,
	input  wire logic                  tx_take,
	output logic      [7:0]            tx_byte_q,
	output logic                       tx_byte_valid_q,
	input  wire logic                  rx_push,
	input  wire logic [7:0]            rx_byte,
	output logic      [5:0]            tx_count_q,
	output logic      [5:0]            rx_count_q
);

	logic        wr_access;
	logic        rd_setup;
	logic        tx_hit;
	logic        rx_hit;
	logic [2:0]  acc_bytes;
	logic [2:0]  tx_push_n;
	logic [2:0]  tx_pop_n;
	logic [2:0]  rx_push_n;
	logic [2:0]  rx_pop_n;
	logic [31:0] tx_peek;
	logic [31:0] rx_peek;
	logic [31:0] rd_mask;
	logic [31:0] prdata_d;

	// Bus phases: writes commit in the access phase, reads are served from the setup
	// phase so that read data is registered in time for the access phase
	assign wr_access = apb.sel && apb.enable && apb.write;
	assign rd_setup  = apb.sel && !apb.enable && !apb.write;
	assign acc_bytes = sfdp_pkg::sfdp_bytes(apb.size);

	// Window decode on the low ten address bits; any offset in range is the FIFO port
	assign tx_hit = (apb.addr >= sfdp_pkg::TX_WIN_LO) && (apb.addr <= sfdp_pkg::TX_WIN_HI);
	assign rx_hit = (apb.addr >= sfdp_pkg::RX_WIN_LO) && (apb.addr <= sfdp_pkg::RX_WIN_HI);

	// Transmit push: whole write dropped when it would overflow, and addresses past
	// the window top never decode, so overrunning burst data is lost
	always_comb begin
		tx_push_n = 3'h0;
		if (wr_access && tx_hit) begin
			if (6'(tx_count_q + 6'(acc_bytes)) <= 6'(DEPTH)) begin
				tx_push_n = acc_bytes;
			end
		end
	end

	// Shifter takes one byte per request while data is present
	assign tx_pop_n = (tx_take && (tx_count_q != 6'h00)) ? 3'h1 : 3'h0;

	// Receive push from the shifter; a byte arriving to a full FIFO is discarded
	assign rx_push_n = (rx_push && (rx_count_q < 6'(DEPTH))) ? 3'h1 : 3'h0;

	// Receive pop only when the FIFO holds at least the requested size
	always_comb begin
		rx_pop_n = 3'h0;
		if (rd_setup && rx_hit && (6'(acc_bytes) <= rx_count_q)) begin
			rx_pop_n = acc_bytes;
		end
	end

	// Lanes above the access size read as zero
	always_comb begin
		unique case (acc_bytes)
			3'h1:    rd_mask = 32'h0000_00FF;
			3'h2:    rd_mask = 32'h0000_FFFF;
			3'h4:    rd_mask = 32'hFFFF_FFFF;
			default: rd_mask = 32'h0000_0000;
		endcase
	end

	// Read data select: empty FIFO and every unmapped offset answer zero
	always_comb begin
		prdata_d = sfdp_pkg::READ_ZERO;
		if (rx_hit && (rx_count_q != 6'h00)) begin
			prdata_d = rx_peek & rd_mask;
		end
	end

	// Transmit FIFO, written at its in pointer whatever the offset
	sfdp_byte_fifo #(
		.DEPTH (DEPTH),
		.CW    (6)
	) u_tx_fifo (
		.clk       (clk),
		.resetn    (resetn),
		.push_n    (tx_push_n),
		.push_data (apb.wdata),
		.pop_n     (tx_pop_n),
		.peek_data (tx_peek),
		.count_q   (tx_count_q)
	);

	// Receive FIFO, read at its out pointer whatever the offset
	sfdp_byte_fifo #(
		.DEPTH (DEPTH),
		.CW    (6)
	) u_rx_fifo (
		.clk       (clk),
		.resetn    (resetn),
		.push_n    (rx_push_n),
		.push_data ({24'h00_0000, rx_byte}),
		.pop_n     (rx_pop_n),
		.peek_data (rx_peek),
		.count_q   (rx_count_q)
	);

	// Read data register; held between reads so the access phase sees a stable value
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prdata_q <= sfdp_pkg::RX_RESET_VAL;
		end else if (rd_setup) begin
			prdata_q <= prdata_d;
		end
	end

	// Byte handed to the shifter, valid for one cycle after each granted take
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_byte_q       <= 8'h00;
			tx_byte_valid_q <= 1'b0;
		end else begin
			tx_byte_valid_q <= (tx_pop_n != 3'h0);
			if (tx_pop_n != 3'h0) begin
				tx_byte_q <= tx_peek[7:0];
			end
		end
	end

	// A fitting write grows the transmit count by exactly the access size
	chk_tx_push_grow: assert property (@(posedge clk) disable iff (!resetn)
		(wr_access && tx_hit && (acc_bytes != 3'h0) && !tx_take
			&& (6'(tx_count_q + 6'(acc_bytes)) <= 6'(DEPTH)))
		|=> (tx_count_q == 6'($past(tx_count_q) + 6'($past(acc_bytes)))))
		else $error("transmit count did not grow by access size");

	// A write that does not fit leaves the count alone
	chk_tx_full_drop: assert property (@(posedge clk) disable iff (!resetn)
		(wr_access && tx_hit && !tx_take && (6'(tx_count_q + 6'(acc_bytes)) > 6'(DEPTH)))
		|=> $stable(tx_count_q))
		else $error("overflowing transmit write changed the FIFO");

	// Writes outside the transmit window never add bytes
	chk_tx_out_window: assert property (@(posedge clk) disable iff (!resetn)
		(wr_access && ((apb.addr < sfdp_pkg::TX_WIN_LO) || (apb.addr > sfdp_pkg::TX_WIN_HI)))
		|=> (tx_count_q <= $past(tx_count_q)))
		else $error("write outside transmit window entered FIFO");

	// An empty receive FIFO reads as zero in the access phase
	chk_rx_empty_zero: assert property (@(posedge clk) disable iff (!resetn)
		(rd_setup && rx_hit && (rx_count_q == 6'h00)) |=> (prdata_q == 32'h0000_0000))
		else $error("empty receive read returned nonzero");

	// A read that fits pops exactly its size
	chk_rx_pop_size: assert property (@(posedge clk) disable iff (!resetn)
		(rd_setup && rx_hit && !rx_push && (acc_bytes != 3'h0) && (6'(acc_bytes) <= rx_count_q))
		|=> (rx_count_q == 6'($past(rx_count_q) - 6'($past(acc_bytes)))))
		else $error("receive read did not pop its size");

	// An over-sized read never drains the FIFO
	chk_rx_over_keep: assert property (@(posedge clk) disable iff (!resetn)
		(rd_setup && rx_hit && (6'(acc_bytes) > rx_count_q)) |=> (rx_count_q >= $past(rx_count_q)))
		else $error("over-sized receive read popped bytes");

	// Reads outside the receive window give zero and leave the count
	chk_rx_out_zero: assert property (@(posedge clk) disable iff (!resetn)
		(rd_setup && !rx_hit) |=> ((prdata_q == 32'h0000_0000) && (rx_count_q >= $past(rx_count_q))))
		else $error("read outside receive window returned data or popped");

	// Counts never exceed the depth
	chk_count_bound: assert property (@(posedge clk) disable iff (!resetn)
		(tx_count_q <= 6'(DEPTH)) && (rx_count_q <= 6'(DEPTH)))
		else $error("FIFO count beyond depth");

	// A granted take delivers a byte in the next cycle and consumes one entry
	chk_tx_take_byte: assert property (@(posedge clk) disable iff (!resetn)
		(tx_take && (tx_count_q != 6'h00) && !wr_access) |=> (tx_byte_valid_q
			&& (tx_count_q == 6'($past(tx_count_q) - 6'h01))))
		else $error("transmit take did not deliver a byte");

	// A take from an empty transmit FIFO must not fake a byte for the shifter
	chk_tx_empty_take: assert property (@(posedge clk) disable iff (!resetn)
		(tx_take && (tx_count_q == 6'h00)) |=> !tx_byte_valid_q)
		else $error("take from empty transmit FIFO gave a byte");

	// A byte offered to a full receive FIFO is lost, the count stays
	chk_rx_full_drop: assert property (@(posedge clk) disable iff (!resetn)
		(rx_push && (rx_count_q == 6'(DEPTH)) && !(rd_setup && rx_hit))
		|=> $stable(rx_count_q))
		else $error("byte pushed into full receive FIFO");

	// The receive window is read only: bus writes never add received bytes
	chk_rx_write_ignored: assert property (@(posedge clk) disable iff (!resetn)
		(wr_access && !rx_push) |=> (rx_count_q <= $past(rx_count_q)))
		else $error("bus write changed the receive FIFO");

	// A fitting halfword read returns zero in the upper lanes
	chk_rx_half_lanes: assert property (@(posedge clk) disable iff (!resetn)
		(rd_setup && rx_hit && (acc_bytes == 3'h2) && (rx_count_q >= 6'h02))
		|=> (prdata_q[31:16] == 16'h0000))
		else $error("receive halfword read returned upper lanes");

endmodule : sfdp_data_port
`default_nettype wire

// File: tb/sfdp_apb_master.sv
// Bus master model that reaches the data windows with two-phase transfers
`timescale 1ns/1ps
`default_nettype none
module sfdp_apb_master (
	input  wire logic                    clk,
	input  wire logic [31:0]             prdata_q,
	output var sfdp_pkg::sfdp_apb_req_t  apb
);
	// Idle bus from time zero, address parked outside both windows
	initial begin
		apb = '0;
	end
	// Write transfer; request held until the access edge, data scrambled on release
	task automatic wr(input logic [9:0] a, input logic [31:0] d, input sfdp_pkg::sfdp_size_t s);
		@(posedge clk) #1;
		apb = '{sel: 1'b1, enable: 1'b0, write: 1'b1, addr: a, wdata: d, size: s};
		@(posedge clk) #1;
		apb.enable = 1'b1;
		@(posedge clk) #1;
		apb = '{sel: 1'b0, enable: 1'b0, write: 1'b0, addr: 10'h000, wdata: ~d, size: s};
	endtask : wr
	// Read transfer; data taken at the edge that ends the access phase
	task automatic rd(input logic [9:0] a, input sfdp_pkg::sfdp_size_t s, output logic [31:0] d);
		@(posedge clk) #1;
		apb = '{sel: 1'b1, enable: 1'b0, write: 1'b0, addr: a, wdata: 32'h0, size: s};
		@(posedge clk) #1;
		apb.enable = 1'b1;
		@(posedge clk);
		d = prdata_q;
		#1 apb = '0;
	endtask : rd
endmodule : sfdp_apb_master
`default_nettype wire

// File: tb/sfdp_data_port_tb.sv
// Self-checking bench for the transmit and receive data windows
`timescale 1ns/1ps
`default_nettype none
module sfdp_data_port_tb;
	logic                    clk, resetn, tx_take, rx_push, tx_byte_valid_q;
	logic [7:0]              rx_byte, tx_byte_q;
	logic [31:0]             prdata_q;
	logic [5:0]              tx_count_q, rx_count_q;
	sfdp_pkg::sfdp_apb_req_t apb;
	int                      err_total, total_checks, seed;
	logic [7:0]              txq[$], rxq[$];

	sfdp_data_port #(.DEPTH(32)) sfdp_data_port_i (.clk(clk), .resetn(resetn), .apb(apb),
		.prdata_q(prdata_q), .tx_take(tx_take), .tx_byte_q(tx_byte_q), .tx_byte_valid_q(tx_byte_valid_q),
		.rx_push(rx_push), .rx_byte(rx_byte), .tx_count_q(tx_count_q), .rx_count_q(rx_count_q));
	sfdp_apb_master mst (.clk(clk), .prdata_q(prdata_q), .apb(apb));

	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_sim

	function automatic int nby(input sfdp_pkg::sfdp_size_t s);
		return (s == sfdp_pkg::SFDP_SIZE_WORD) ? 4 : (s == sfdp_pkg::SFDP_SIZE_HALF) ? 2 :
			(s == sfdp_pkg::SFDP_SIZE_BYTE) ? 1 : 0;
	endfunction : nby

	// Model: a write enters only inside the window and only if it fits whole
	task automatic twr(input logic [9:0] a, input sfdp_pkg::sfdp_size_t s);
		logic [31:0] d;
		d = $random(seed);
		mst.wr(a, d, s);
		if (a >= 10'h010 && a <= 10'h02F && txq.size() + nby(s) <= 32)
			for (int i = 0; i < nby(s); i++) txq.push_back(d[8*i +: 8]);
		chk("tx_count", 32'(tx_count_q), 32'(txq.size()));
	endtask : twr

	// One byte requested by the shifter; an empty FIFO gives no pulse
	task automatic take;
		@(posedge clk) #1 tx_take = 1'b1;
		@(posedge clk) #1 tx_take = 1'b0;
		chk("tx_valid", 32'(tx_byte_valid_q), 32'(txq.size() != 0));
		if (txq.size() != 0) chk("tx_byte", 32'(tx_byte_q), 32'(txq.pop_front()));
	endtask : take

	task automatic rxp(input int k);
		repeat (k) begin
			@(posedge clk) #1;
			rx_push = 1'b1;
			rx_byte = 8'($random(seed));
			if (rxq.size() < 32) rxq.push_back(rx_byte);
		end
		@(posedge clk) #1 rx_push = 1'b0;
		chk("rx_count", 32'(rx_count_q), 32'(rxq.size()));
	endtask : rxp

	// Over-reads of a non-empty FIFO give undefined data, so only the count is compared
	task automatic rrd(input logic [9:0] a, input sfdp_pkg::sfdp_size_t s);
		logic [31:0] d, e;
		logic        win, over;
		e = '0;
		win = a >= 10'h030 && a <= 10'h04F;
		over = win && rxq.size() != 0 && nby(s) > rxq.size();
		if (win && !over) for (int i = 0; i < nby(s) && rxq.size() != 0; i++) e[8*i +: 8] = rxq.pop_front();
		mst.rd(a, s, d);
		if (!over) chk("rx_data", d, e);
		chk("rx_count", 32'(rx_count_q), 32'(rxq.size()));
	endtask : rrd

	// Hang guard
	initial begin
		#200us;
		err_total++;
		end_sim();
	end

	initial begin
		seed = 32'hFBA2A066;
		{resetn, tx_take, rx_push, rx_byte, err_total, total_checks} = '0;
		repeat (20) @(posedge clk);
		chk("reset_rdata", prdata_q, 32'h0);
		chk("reset_count", {20'h0, tx_count_q, rx_count_q}, 32'h0);
		chk("reset_tx", {23'h0, tx_byte_valid_q, tx_byte_q}, 32'h0);
		#1 resetn = 1'b1;
		// Edges of the transmit window, then a halfword burst that overflows by one
		rrd(10'h030, sfdp_pkg::SFDP_SIZE_WORD);
		twr(10'h00F, sfdp_pkg::SFDP_SIZE_BYTE);
		twr(10'h030, sfdp_pkg::SFDP_SIZE_WORD);
		twr(10'h02F, sfdp_pkg::SFDP_SIZE_BYTE);
		for (int i = 0; i < 16; i++) twr(10'(16 + 2*i), sfdp_pkg::SFDP_SIZE_HALF);
		chk("rx_count", 32'(rx_count_q), 32'h0);
		repeat (33) take();
		// Word burst fills the FIFO, the next byte is dropped
		for (int i = 0; i < 8; i++) twr(10'(16 + 4*i), sfdp_pkg::SFDP_SIZE_WORD);
		twr(10'h010, sfdp_pkg::SFDP_SIZE_BYTE);
		twr(10'h020, sfdp_pkg::SFDP_SIZE_RSVD);
		repeat (32) take();
		$display("transmit test done");
		// Receive: top offset, over-read, past the window, odd offset
		rxp(6);
		rrd(10'h04C, sfdp_pkg::SFDP_SIZE_WORD);
		rrd(10'h030, sfdp_pkg::SFDP_SIZE_WORD);
		rrd(10'h050, sfdp_pkg::SFDP_SIZE_HALF);
		rrd(10'h031, sfdp_pkg::SFDP_SIZE_HALF);
		rrd(10'h030, sfdp_pkg::SFDP_SIZE_BYTE);
		rxp(33);
		for (int i = 0; i < 8; i++) rrd(10'(48 + 4*i), sfdp_pkg::SFDP_SIZE_WORD);
		$display("receive test done");
		end_sim();
	end
endmodule : sfdp_data_port_tb
`default_nettype wire
